// >>> hw/pmc_ctrl.sv
// Top of the power mode controller: mode sequencing and gating outputs
`timescale 1ns/1ps
module pmc_ctrl
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Supply monitor: high while supply is below threshold
  input wire logic i_supply_low,
  // Processor writes to power control and power unit config
  input wire logic i_pcr_wr,
  input wire logic [1:0] i_pcr_wdata,
  input wire logic i_puc_wr,
  input wire logic [1:0] i_puc_wdata,
  // Processor says the current instruction has finished
  input wire logic i_instr_done,
  // Low power clock tree mode request (nonzero enables it)
  input wire logic i_lp_clk_mode,
  // Peripheral clock requests and software enables
  input wire logic [PCLK_W-1:0] i_pclk_req,
  input wire logic [PCLK_W-1:0] i_pclk_en,
  // Wake sources
  input wire logic i_irq_any,
  input wire logic [WK_W-1:0] i_wake_src,
  // Register readback
  output logic [1:0] o_pcr,
  output logic [1:0] o_puc,
  // Core control
  output logic o_cpu_halt,
  output logic o_cpu_reset,
  output logic [15:0] o_reset_vector,
  output logic o_resume,
  // Clock and power gating
  output logic [PCLK_W-1:0] o_pclk_gate_en,
  output logic o_sysclk_en,
  output logic o_precision_osc_en,
  output logic o_internal_osc_en,
  output logic o_ext_osc_en,
  output logic o_rtc_osc_en,
  output logic o_core_supply_en,
  // Mode status
  output pmc_mode_t o_mode
);
  import pmc_pkg::*;

  // All state in one record
  typedef struct packed {
    pmc_mode_t mode; // Current power mode
    logic [1:0] pcr; // Power control bits
    logic [1:0] puc; // Power unit config bits
    logic pend; // A mode bit awaits instruction completion
    logic halt; // Processor halted
    logic creset; // Processor held in reset
    logic resume; // One-cycle resume pulse
    logic [PCLK_W-1:0] pgate; // Peripheral clock enables
    logic sysclk; // System clock running
    logic posc; // Precision oscillator
    logic iosc; // Other internal oscillators
    logic rtc; // Real time clock oscillator
    logic supply; // Core supply on
  } pmc_state_t;

  pmc_wake_if wk ();
  pmc_state_t st_reg;
  pmc_state_t st_next;
  logic any_reset; // Reset from pin or supply monitor

  // Wake source combining
  pmc_wake u_wake (
    .i_irq_any(i_irq_any),
    .i_wake_src(i_wake_src),
    .wk(wk)
  );

  assign any_reset = i_rst | i_supply_low;

  // Pick next mode once an instruction completes
  function automatic pmc_mode_t pmc_entry(input logic [1:0] pcr, input logic [1:0] puc,
                                          input logic lp);
    pmc_mode_t m;
    m = lp ? PMC_LP_ACTIVE : PMC_ACTIVE;
    // Priority keeps exactly one mode if several bits are set
    if (puc[PUC_SLEEP_BIT])
      m = PMC_SLEEP;
    else if (puc[PUC_SUSPEND_BIT])
      m = PMC_SUSPEND;
    else if (pcr[PCR_STOP_BIT])
      m = PMC_STOP;
    else if (pcr[PCR_IDLE_BIT])
      m = lp ? PMC_LP_IDLE : PMC_IDLE;
    return m;
  endfunction

  // Next state logic
  always_comb
  begin
    st_next = st_reg;
    st_next.resume = 1'b0;
    st_next.creset = 1'b0;
    // Software writes; the mode takes effect later
    if (i_pcr_wr)
    begin
      st_next.pcr = i_pcr_wdata;
      st_next.pend = |i_pcr_wdata;
    end
    if (i_puc_wr)
    begin
      st_next.puc = i_puc_wdata;
      st_next.pend = st_next.pend | (|i_puc_wdata);
    end
    unique case (st_reg.mode)
      PMC_ACTIVE, PMC_LP_ACTIVE:
      begin
        // wait for setting instruction to finish
        if (st_reg.pend && i_instr_done)
        begin
          // A write in the completing cycle stays pending, so it is not lost
          st_next.pend = (i_pcr_wr && (|i_pcr_wdata)) || (i_puc_wr && (|i_puc_wdata));
          st_next.mode = pmc_entry(st_reg.pcr, st_reg.puc, i_lp_clk_mode);
        end
        else if (!st_reg.pend)
        begin
          // entering or leaving low power active via clock mode
          st_next.mode = i_lp_clk_mode ? PMC_LP_ACTIVE : PMC_ACTIVE;
        end
      end
      PMC_IDLE, PMC_LP_IDLE:
      begin
        if (wk.irq_wake)
        begin
          st_next.pcr[PCR_IDLE_BIT] = 1'b0;
          st_next.resume = 1'b1;
          // low power idle wakes to low power active
          st_next.mode = (st_reg.mode == PMC_LP_IDLE) ? PMC_LP_ACTIVE : PMC_ACTIVE;
        end
      end
      PMC_STOP:
      begin
        st_next.mode = PMC_STOP;
      end
      PMC_SUSPEND:
      begin
        if (wk.susp_wake)
        begin
          st_next.puc[PUC_SUSPEND_BIT] = 1'b0;
          st_next.resume = 1'b1;
          st_next.mode = i_lp_clk_mode ? PMC_LP_ACTIVE : PMC_ACTIVE;
        end
      end
      PMC_SLEEP:
      begin
        if (wk.sleep_wake)
        begin
          st_next.puc[PUC_SLEEP_BIT] = 1'b0;
          st_next.resume = 1'b1;
          st_next.mode = i_lp_clk_mode ? PMC_LP_ACTIVE : PMC_ACTIVE;
        end
      end
      // Illegal code: fall back to normal active
      default:
        st_next.mode = PMC_ACTIVE;
    endcase
    // Gating derived from the mode being entered
    // halt only, program counter untouched
    // idle keeps peripherals and storage alive
    st_next.halt = (st_next.mode != PMC_ACTIVE) && (st_next.mode != PMC_LP_ACTIVE);
    // low power modes clock requesters only
    if (st_next.mode == PMC_LP_ACTIVE || st_next.mode == PMC_LP_IDLE)
      st_next.pgate = i_pclk_req & i_pclk_en;
    else if (st_next.mode == PMC_SUSPEND || st_next.mode == PMC_SLEEP)
      st_next.pgate = '0;
    else
      st_next.pgate = i_pclk_en;
    st_next.sysclk = (st_next.mode != PMC_SUSPEND) && (st_next.mode != PMC_SLEEP);
    st_next.posc = st_next.sysclk && (st_next.mode != PMC_STOP);
    st_next.iosc = st_next.sysclk;
    st_next.rtc = 1'b1;
    st_next.supply = (st_next.mode != PMC_SLEEP);
    if (any_reset)
    begin
      st_next = '0;
      st_next.mode = PMC_ACTIVE;
      st_next.pcr = PCR_RESET;
      st_next.puc = PUC_RESET;
      st_next.creset = 1'b1;
      st_next.pgate = i_pclk_en;
      st_next.sysclk = 1'b1;
      st_next.posc = 1'b1;
      st_next.iosc = 1'b1;
      st_next.rtc = 1'b1;
      st_next.supply = 1'b1;
    end
  end

  // State register; reset handled in the next-state logic
  always_ff @(posedge i_sys_clk)
  begin
    st_reg <= st_next;
  end

  // Outputs straight from state flip-flops, reset vector from a constant
  assign o_pcr = st_reg.pcr;
  assign o_puc = st_reg.puc;
  assign o_cpu_halt = st_reg.halt;
  assign o_cpu_reset = st_reg.creset;
  assign o_reset_vector = RESET_VECTOR;
  assign o_resume = st_reg.resume;
  assign o_pclk_gate_en = st_reg.pgate;
  assign o_sysclk_en = st_reg.sysclk;
  assign o_precision_osc_en = st_reg.posc;
  assign o_internal_osc_en = st_reg.iosc;
  // External oscillator kept in stop, off in suspend and sleep
  assign o_ext_osc_en = st_reg.iosc;
  assign o_rtc_osc_en = st_reg.rtc;
  assign o_core_supply_en = st_reg.supply;
  assign o_mode = st_reg.mode;
endmodule : pmc_ctrl

// >>> inc/pmc_pkg.sv
// Package of constants and types for the power mode controller
package pmc_pkg;
  // Power control register bit positions
  localparam int PCR_IDLE_BIT = 0;
  localparam int PCR_STOP_BIT = 1;
  localparam logic [1:0] PCR_RESET = 2'h0;
  // Power unit config bit positions
  localparam int PUC_SUSPEND_BIT = 0;
  localparam int PUC_SLEEP_BIT = 1;
  localparam logic [1:0] PUC_RESET = 2'h0;
  // Wake source bit positions (suspend and sleep)
  localparam int WK_TOUCH = 0;
  localparam int WK_RTC = 1;
  localparam int WK_PORT = 2;
  localparam int WK_I2C = 3;
  localparam int WK_PIN = 4;
  localparam int WK_W = 5;
  // Peripheral clock branches
  localparam int PCLK_W = 8;
  // Idle wake limit in cycles
  localparam int IDLE_WAKE_CYCLES = 2;
  localparam logic [1:0] WAKE_CNT_RESET = 2'h0;
  // Reset fetch address
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // One-hot power modes
  typedef enum logic [6:0] {
    PMC_ACTIVE = 7'h01,
    PMC_LP_ACTIVE = 7'h02,
    PMC_IDLE = 7'h04,
    PMC_LP_IDLE = 7'h08,
    PMC_STOP = 7'h10,
    PMC_SUSPEND = 7'h20,
    PMC_SLEEP = 7'h40
  } pmc_mode_t;
endpackage : pmc_pkg

// >>> inc/pmc_wake_if.sv
// Interface carrying wake requests from the wake combiner to the controller
`timescale 1ns/1ps
interface pmc_wake_if;
  logic irq_wake; // Any enabled interrupt
  logic susp_wake; // Suspend wake event
  logic sleep_wake; // Sleep wake event
  modport src (output irq_wake, output susp_wake, output sleep_wake);
  modport dst (input irq_wake, input susp_wake, input sleep_wake);
endinterface : pmc_wake_if

// >>> hw/pmc_wake.sv
// Wake source combiner for the power mode controller
`timescale 1ns/1ps
module pmc_wake
  import pmc_pkg::*;
(
  // Raw sources
  input wire logic i_irq_any,
  input wire logic [WK_W-1:0] i_wake_src,
  // Combined wake requests
  pmc_wake_if.src wk
);
  // Suspend may wake on any source including touch sense
  // suspend wake sources
  assign wk.susp_wake = |i_wake_src;
  // Sleep has no touch sense converter powered, so it is ignored
  // sleep wake sources
  assign wk.sleep_wake = i_wake_src[WK_RTC] | i_wake_src[WK_PORT] | i_wake_src[WK_I2C]
    | i_wake_src[WK_PIN];
  // Any enabled interrupt ends either idle mode
  // interrupt wake
  assign wk.irq_wake = i_irq_any;
endmodule : pmc_wake

// >>> testbench/pmc_checker.sv
// Port checker for the power mode controller
`timescale 1ns/1ps
module pmc_checker
  import pmc_pkg::*;
(
  // Clock, reset, inputs
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_supply_low,
  input wire logic i_lp_clk_mode,
  input wire logic i_irq_any,
  // Outputs watched
  input wire logic o_cpu_halt,
  input wire logic o_cpu_reset,
  input wire logic [15:0] o_reset_vector,
  input wire logic o_resume,
  input wire logic o_sysclk_en,
  input wire logic o_precision_osc_en,
  input wire logic o_internal_osc_en,
  input wire logic o_rtc_osc_en,
  input wire logic o_core_supply_en,
  input wire pmc_mode_t o_mode
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Wake lands in active with a resume pulse
  sequence s_wake;
    ##[1:2] (o_mode == PMC_ACTIVE && o_resume && !o_cpu_halt);
  endsequence
  AST_RST: assert property (disable iff (1'b0)
    i_rst |=> o_mode == PMC_ACTIVE && o_cpu_reset) else $error("reset not to active");
  AST_SUPPLY: assert property (disable iff (1'b0)
    i_supply_low |=> o_cpu_reset) else $error("low supply not held in reset");
  AST_VECTOR: assert property (
    $fell(o_cpu_reset) |-> o_reset_vector == RESET_VECTOR && o_mode == PMC_ACTIVE
    && !o_cpu_halt) else $error("bad restart after reset");
  AST_IDLE_WAKE: assert property (
    o_mode == PMC_IDLE && i_irq_any && !i_supply_low && !i_lp_clk_mode |-> s_wake)
    else $error("idle wake late");
  AST_LPIDLE_WAKE: assert property (
    o_mode == PMC_LP_IDLE && i_irq_any && i_lp_clk_mode && !i_supply_low
    |=> o_mode == PMC_LP_ACTIVE) else $error("low power idle wake wrong");
  AST_STOP: assert property (
    o_mode == PMC_STOP && !i_supply_low |-> !o_precision_osc_en ##1 o_mode == PMC_STOP)
    else $error("stop left or oscillator on");
  AST_SUSPEND: assert property (
    o_mode == PMC_SUSPEND |-> !o_sysclk_en && !o_internal_osc_en && !o_precision_osc_en)
    else $error("suspend gating wrong");
  AST_SLEEP: assert property (
    o_mode == PMC_SLEEP |-> !o_core_supply_en && o_rtc_osc_en) else $error("sleep gating");
  AST_ONEHOT: assert property (
    $onehot(o_mode)) else $error("mode not one-hot");
  AST_HALT: assert property (
    o_mode inside {PMC_IDLE, PMC_LP_IDLE} |-> o_cpu_halt) else $error("idle not halted");
endmodule // pmc_checker

bind pmc_ctrl pmc_checker u_pmc_checker (.i_sys_clk, .i_rst, .i_supply_low, .i_lp_clk_mode,
  .i_irq_any, .o_cpu_halt, .o_cpu_reset, .o_reset_vector, .o_resume, .o_sysclk_en,
  .o_precision_osc_en, .o_internal_osc_en, .o_rtc_osc_en, .o_core_supply_en, .o_mode);

// >>> testbench/pmc_core_model.sv
// Processor core model: finishes the writing instruction
`timescale 1ns/1ps
module pmc_core_model
(
  // Clock and register write strobe
  input wire logic i_sys_clk,
  input wire logic i_wr,
  // Instruction done, one cycle after the write
  output logic o_done
);
  logic wr_reg = 1'b0;
  initial o_done = 1'b0;
  // Done never shares the write cycle
  always @(posedge i_sys_clk)
    wr_reg <= i_wr;
  always @(negedge i_sys_clk)
    o_done <= wr_reg;
endmodule // pmc_core_model

// >>> testbench/power_mode_controller_test.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
module power_mode_controller_test;
  import pmc_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_supply_low = 1'b0;
  logic i_pcr_wr = 1'b0;
  logic [1:0] i_pcr_wdata = 2'h0;
  logic i_puc_wr = 1'b0;
  logic [1:0] i_puc_wdata = 2'h0;
  logic i_instr_done;
  logic i_lp_clk_mode = 1'b0;
  logic [PCLK_W-1:0] i_pclk_req = 8'h5a;
  logic [PCLK_W-1:0] i_pclk_en = 8'h3c;
  logic i_irq_any = 1'b0;
  logic [WK_W-1:0] i_wake_src = 5'h00;
  logic [1:0] o_pcr, o_puc;
  logic o_cpu_halt, o_cpu_reset, o_resume, o_sysclk_en, o_precision_osc_en;
  logic o_internal_osc_en, o_ext_osc_en, o_rtc_osc_en, o_core_supply_en;
  logic [15:0] o_reset_vector;
  logic [PCLK_W-1:0] o_pclk_gate_en;
  pmc_mode_t o_mode;
  int errors = 0;
  int checked = 0;
  initial
  begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  pmc_ctrl u_pmc_ctrl (.i_sys_clk, .i_rst, .i_supply_low, .i_pcr_wr, .i_pcr_wdata, .i_puc_wr,
    .i_puc_wdata, .i_instr_done, .i_lp_clk_mode, .i_pclk_req, .i_pclk_en, .i_irq_any,
    .i_wake_src, .o_pcr, .o_puc, .o_cpu_halt, .o_cpu_reset, .o_reset_vector, .o_resume,
    .o_pclk_gate_en, .o_sysclk_en, .o_precision_osc_en, .o_internal_osc_en, .o_ext_osc_en,
    .o_rtc_osc_en, .o_core_supply_en, .o_mode);
  pmc_core_model u_pmc_core_model (.i_sys_clk, .i_wr(i_pcr_wr | i_puc_wr), .o_done(i_instr_done));
  task automatic tally_and_finish;
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bounded wait for a mode; a timeout ends the run
  task automatic wait_mode(input pmc_mode_t m, input int lim);
    int n;
    n = 0;
    while (o_mode !== m && n < lim)
    begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("mode", m, o_mode);
    if (o_mode !== m)
      tally_and_finish();
  endtask
  // One-cycle register write, pcr when p is set
  task automatic wr(input logic p, input logic [1:0] d);
    i_pcr_wr = p;
    i_puc_wr = !p;
    i_pcr_wdata = d;
    i_puc_wdata = d;
    @(negedge i_sys_clk);
    i_pcr_wr = 1'b0;
    i_puc_wr = 1'b0;
  endtask
  task automatic t_idle(input logic lp);
    i_lp_clk_mode = lp;
    @(negedge i_sys_clk);
    wr(1'b1, 2'h1);
    chk("early", lp ? PMC_LP_ACTIVE : PMC_ACTIVE, o_mode);
    wait_mode(lp ? PMC_LP_IDLE : PMC_IDLE, 3);
    chk("halt", 1, o_cpu_halt);
    if (lp)
      chk("gate_lpidle", i_pclk_req & i_pclk_en, o_pclk_gate_en);
    else
      chk("gate_idle", i_pclk_en, o_pclk_gate_en);
    chk("sysclk_idle", 1, o_sysclk_en);
    i_irq_any = 1'b1;
    wait_mode(lp ? PMC_LP_ACTIVE : PMC_ACTIVE, 2);
    chk("resume", 1, o_resume);
    chk("pcr", 0, o_pcr);
    chk("run", 0, o_cpu_halt);
    if (lp)
      chk("gate", i_pclk_req & i_pclk_en, o_pclk_gate_en);
    i_irq_any = 1'b0;
    i_lp_clk_mode = 1'b0;
    wait_mode(PMC_ACTIVE, 3);
  endtask
  task automatic t_stop;
    wr(1'b1, 2'h2);
    wait_mode(PMC_STOP, 3);
    chk("xosc", 1, o_ext_osc_en);
    i_irq_any = 1'b1;
    i_wake_src = 5'h0f;
    repeat (3) @(negedge i_sys_clk);
    chk("stop", PMC_STOP, o_mode);
    i_irq_any = 1'b0;
    i_wake_src = 5'h00;
    i_supply_low = 1'b1;
    @(negedge i_sys_clk);
    chk("sup_rst", 1, o_cpu_reset);
    i_supply_low = 1'b0;
    wait_mode(PMC_ACTIVE, 2);
  endtask
  task automatic t_low(input logic [1:0] cfg, input int s);
    wr(1'b0, cfg);
    wait_mode(cfg[PUC_SLEEP_BIT] ? PMC_SLEEP : PMC_SUSPEND, 3);
    chk("iosc", 0, o_internal_osc_en);
    chk("sysclk_low", 0, o_sysclk_en);
    chk("supply", cfg[PUC_SLEEP_BIT] ? 0 : 1, o_core_supply_en);
    i_wake_src = 5'h01 << s;
    @(negedge i_sys_clk);
    i_wake_src = 5'h00;
    if (cfg[PUC_SLEEP_BIT] && s == WK_TOUCH)
    begin
      chk("touch", PMC_SLEEP, o_mode);
      i_wake_src = 5'h10;
      @(negedge i_sys_clk);
      i_wake_src = 5'h00;
    end
    wait_mode(PMC_ACTIVE, 3);
    chk("puc", 0, o_puc);
  endtask
  initial
  begin
    repeat (5) @(negedge i_sys_clk);
    i_rst = 1'b0;
    chk("cpu_rst", 1, o_cpu_reset);
    chk("pcr", 0, o_pcr);
    t_idle(1'b0);
    t_idle(1'b1);
    wr(1'b1, 2'h1);
    wait_mode(PMC_IDLE, 3);
    i_rst = 1'b1;
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    wait_mode(PMC_ACTIVE, 2);
    chk("pcr", 0, o_pcr);
    chk("cpu_rst_idle", 1, o_cpu_reset);
    chk("vector", RESET_VECTOR, o_reset_vector);
    t_stop();
    for (int s = 0; s < WK_W; s++)
    begin
      t_low(2'h1, s);
      t_low(2'h2, s);
    end
    tally_and_finish();
  end
endmodule // power_mode_controller_test
